// ==== core/fnd_core.sv ====
// Reference divider, sigma-delta feedback divider, phase detector and fast lock cell control.
// Assumes reference and divided VCO inputs are synchronous levels well below mclk/2.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Falling reference edge is the active edge fed to the detector.
// - Power-down disconnects the reference buffer and closes the shunt switch.
// - A 4-bit counter divides the reference into the detector reference.
// - Optional toggle stage halves the divided reference for even duty.
// - Timer clock comes from detector reference falling edge; rising edge is active.
// - Optional doubler ahead of the reference counter for slow references.
// - Overall reference division from 0.5 up to 30.
// - 4/5 or 8/9 prescaler; 8/9 whenever feedback divide exceeds 80.
// - Integer feedback ratio 26 to 255, written apart from the fraction.
// - Third-order sigma-delta dithers divide between integer steps.
// - Average divide equals integer plus fraction over modulus.
// - Detector drives up and down pulses whose width difference tracks phase.
// - Lagging feedback gives net up; leading feedback gives net down.
// - 64 pump cells; all while the fast lock timer runs, one in normal operation.
// - Timers tick at a quarter detector rate and restart on new frequency.
// - After timeout, cells halve each timer tick over six ticks to one.
module fnd_core
	import fnd_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Reference and feedback inputs
	input wire logic ref_clock_in,
	input wire logic vco_div_in,
	// Reference input switches
	output logic ref_buf_connect,
	output logic ref_input_shunt_switch,
	// Detector and divider outputs
	output logic detector_ref_clk,
	output logic pfd_up,
	output logic pfd_down,
	output logic prescaler_hi,
	// Charge pump
	output logic [CELL_COUNT-1:0] cp_cell_en,
	output logic fast_lock
);
	// ==========================================
	// Registers
	fnd_cfg_t cfg_q;
	logic [7:0] int_q;
	logic [11:0] fraction_word_q;
	logic [11:0] mod_q;
	logic [9:0] timer_q;
	logic new_freq;
	fnd_fl_t fl_q;
	logic [6:0] cells_q;
	logic [8:0] n_cur_q;

	assign new_freq = wr && (addr == OFS_INT || addr == OFS_FRACTION_WORD);

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_q <= '{r_div: RST_R_DIV, pd: 1'b0, tog: 1'b0, dbl: 1'b0};
			int_q <= RST_INT;
			fraction_word_q <= RST_FRACTION_WORD;
			mod_q <= RST_MOD;
			timer_q <= RST_TIMER;
		end else if (wr) begin
			if (addr == OFS_CTRL) begin
				cfg_q <= '{r_div: wdata[CTRL_R_LSB +: 4], pd: wdata[CTRL_PD_BIT],
					tog: wdata[CTRL_TOG_BIT], dbl: wdata[CTRL_DBL_BIT]};
			end else if (addr == OFS_INT) begin
				int_q <= wdata[7:0];
			end else if (addr == OFS_FRACTION_WORD) begin
				fraction_word_q <= wdata[11:0];
			end else if (addr == OFS_MOD) begin
				mod_q <= wdata[11:0];
			end else if (addr == OFS_TIMER) begin
				timer_q <= wdata[9:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			if (addr == OFS_CTRL) begin
				rdata <= {24'h00_0000, cfg_q.r_div, 1'b0, cfg_q.pd, cfg_q.tog, cfg_q.dbl};
			end else if (addr == OFS_INT) begin
				rdata <= {24'h00_0000, int_q};
			end else if (addr == OFS_FRACTION_WORD) begin
				rdata <= {20'h0_0000, fraction_word_q};
			end else if (addr == OFS_MOD) begin
				rdata <= {20'h0_0000, mod_q};
			end else if (addr == OFS_TIMER) begin
				rdata <= {22'h00_0000, timer_q};
			end else if (addr == OFS_STATUS) begin
				rdata <= {19'h0_0000, prescaler_hi, 2'b00, 2'(fl_q), 1'b0, cells_q};
			end else begin
				rdata <= 32'h0000_0000;
			end
		end
	end

	// ==========================================
	// Reference input switches
	assign ref_buf_connect = !cfg_q.pd;
	assign ref_input_shunt_switch = cfg_q.pd;

	// ==========================================
	// Reference path
	logic ref_q;
	logic ref_evt;
	logic [3:0] r_eff;
	logic [3:0] r_cnt_q;
	logic r_pulse;
	logic tog_q;
	logic dref_d;
	logic dref_rise;
	logic dref_fall;

	always_ff @(posedge mclk) begin
		if (rst) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= ref_clock_in;
		end
	end

	// Falling edge, plus rising edge when doubled
	assign ref_evt = !cfg_q.pd && ((ref_q && !ref_clock_in) || (cfg_q.dbl && !ref_q && ref_clock_in));
	assign r_eff = (cfg_q.r_div == 4'h0) ? 4'h1 : cfg_q.r_div;
	assign r_pulse = ref_evt && (r_cnt_q >= r_eff - 4'h1);

	always_ff @(posedge mclk) begin
		if (rst || cfg_q.pd) begin
			r_cnt_q <= 4'h0;
		end else if (r_pulse) begin
			r_cnt_q <= 4'h0;
		end else if (ref_evt) begin
			r_cnt_q <= r_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || cfg_q.pd) begin
			tog_q <= 1'b0;
		end else if (r_pulse) begin
			tog_q <= !tog_q;
		end
	end

	assign dref_d = cfg_q.tog ? (tog_q ^ r_pulse) : r_pulse;
	assign dref_rise = dref_d && !detector_ref_clk;
	assign dref_fall = !dref_d && detector_ref_clk;

	always_ff @(posedge mclk) begin
		if (rst) begin
			detector_ref_clk <= 1'b0;
		end else begin
			detector_ref_clk <= dref_d;
		end
	end

	// ==========================================
	// Feedback divider and sigma-delta
	logic vco_q;
	logic vco_rise;
	logic [8:0] fb_cnt_q;
	logic fb_pulse;
	logic [11:0] acc1_q;
	logic [11:0] acc2_q;
	logic [11:0] acc3_q;
	logic c2_q;
	logic c3_q;
	logic c3_qq;
	logic [12:0] s1;
	logic [12:0] s2;
	logic [12:0] s3;
	logic c1;
	logic c2;
	logic c3;
	logic [11:0] n1;
	logic [11:0] n2;
	logic [11:0] n3;
	logic [3:0] sd_off;
	logic [7:0] int_eff;
	logic [8:0] n_next;

	always_ff @(posedge mclk) begin
		if (rst) begin
			vco_q <= 1'b0;
		end else begin
			vco_q <= vco_div_in;
		end
	end

	assign vco_rise = !cfg_q.pd && vco_div_in && !vco_q;
	assign fb_pulse = vco_rise && (fb_cnt_q >= n_cur_q - 9'h001);

	always_ff @(posedge mclk) begin
		if (rst || cfg_q.pd) begin
			fb_cnt_q <= 9'h000;
		end else if (fb_pulse) begin
			fb_cnt_q <= 9'h000;
		end else if (vco_rise) begin
			fb_cnt_q <= fb_cnt_q + 9'h001;
		end
	end

	// Cascaded first-order stages, each wrapping at the modulus
	always_comb begin
		s1 = {1'b0, acc1_q} + {1'b0, fraction_word_q};
		c1 = (mod_q != 12'h000) && (s1 >= {1'b0, mod_q});
		n1 = c1 ? 12'(s1 - {1'b0, mod_q}) : s1[11:0];
		s2 = {1'b0, acc2_q} + {1'b0, n1};
		c2 = (mod_q != 12'h000) && (s2 >= {1'b0, mod_q});
		n2 = c2 ? 12'(s2 - {1'b0, mod_q}) : s2[11:0];
		s3 = {1'b0, acc3_q} + {1'b0, n2};
		c3 = (mod_q != 12'h000) && (s3 >= {1'b0, mod_q});
		n3 = c3 ? 12'(s3 - {1'b0, mod_q}) : s3[11:0];
		sd_off = 4'(c1) + 4'(c2) - 4'(c2_q) + 4'(c3) - {2'b00, c3_q, 1'b0} + 4'(c3_qq);
		int_eff = (int_q < INT_MIN) ? INT_MIN : int_q;
		n_next = {1'b0, int_eff} + {{5{sd_off[3]}}, sd_off};
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			acc1_q <= 12'h000;
			acc2_q <= 12'h000;
			acc3_q <= 12'h000;
			c2_q <= 1'b0;
			c3_q <= 1'b0;
			c3_qq <= 1'b0;
			n_cur_q <= {1'b0, RST_INT};
		end else if (fb_pulse) begin
			acc1_q <= n1;
			acc2_q <= n2;
			acc3_q <= n3;
			c2_q <= c2;
			c3_q <= c3;
			c3_qq <= c3_q;
			n_cur_q <= n_next;
		end
	end

	assign prescaler_hi = n_cur_q > PRESC_HI_ABOVE;

	// ==========================================
	// Phase frequency detector
	logic up_d;
	logic dn_d;

	always_comb begin
		up_d = pfd_up || dref_rise;
		dn_d = pfd_down || fb_pulse;
		if (up_d && dn_d) begin
			up_d = 1'b0;
			dn_d = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || cfg_q.pd) begin
			pfd_up <= 1'b0;
			pfd_down <= 1'b0;
		end else begin
			pfd_up <= up_d;
			pfd_down <= dn_d;
		end
	end

	// ==========================================
	// Fast lock timer and pump cells
	logic [1:0] qdiv_q;
	logic timer_tick;
	logic [9:0] tmr_cnt_q;

	assign timer_tick = dref_fall && (qdiv_q == TICK_LAST);
	assign fast_lock = fl_q != FL_NORMAL;

	always_ff @(posedge mclk) begin
		if (rst || new_freq) begin
			qdiv_q <= 2'h0;
		end else if (dref_fall) begin
			qdiv_q <= qdiv_q + 2'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			fl_q <= FL_NORMAL;
			cells_q <= CELLS_ONE;
			tmr_cnt_q <= 10'h000;
		end else if (new_freq) begin
			fl_q <= FL_FAST;
			cells_q <= CELLS_ALL;
			tmr_cnt_q <= timer_q;
		end else if (timer_tick) begin
			case (fl_q)
				FL_FAST: begin
					if (tmr_cnt_q == 10'h000) begin
						fl_q <= FL_STEP;
					end else begin
						tmr_cnt_q <= tmr_cnt_q - 10'h001;
					end
				end
				FL_STEP: begin
					cells_q <= cells_q >> 1;
					if (cells_q <= 7'h02) begin
						fl_q <= FL_NORMAL;
					end
				end
				default: begin
					cells_q <= CELLS_ONE;
				end
			endcase
		end
	end

	for (genvar i = 0; i < CELL_COUNT; i++) begin : g_cell
		assign cp_cell_en[i] = 7'(i) < cells_q;
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_pfd_not_both: assert property (!(pfd_up && pfd_down)) else $error("up and down both high");
	a_up_on_lag: assert property (dref_rise && !pfd_down && !fb_pulse && !cfg_q.pd |=> pfd_up)
		else $error("no up after reference edge");
	a_down_on_lead: assert property (fb_pulse && !pfd_up && !dref_rise && !cfg_q.pd |=> pfd_down)
		else $error("no down after feedback edge");
	a_ref_fall_edge: assert property (ref_evt && !cfg_q.dbl |-> $past(ref_clock_in) && !ref_clock_in)
		else $error("reference event not on falling edge");
	a_pd_no_load: assert property (cfg_q.pd |-> !ref_buf_connect && ref_input_shunt_switch)
		else $error("reference loaded in power-down");
	a_pd_quiet: assert property (cfg_q.pd |=> !pfd_up && !pfd_down)
		else $error("detector active in power-down");
	a_rdiv_wrap: assert property (r_pulse && !cfg_q.pd |=> r_cnt_q == 4'h0)
		else $error("reference counter did not wrap");
	a_fast_all: assert property (new_freq |=> cells_q == CELLS_ALL && fl_q == FL_FAST && qdiv_q == 2'h0)
		else $error("fast lock not started");
	a_step_halves: assert property (fl_q == FL_STEP && timer_tick && !new_freq |=>
		cells_q == ($past(cells_q) >> 1)) else $error("cells did not halve");
	a_normal_one: assert property (fl_q == FL_NORMAL |-> cells_q == CELLS_ONE && cp_cell_en[1] == 1'b0)
		else $error("normal mode not one cell");
	a_n_range: assert property (fb_pulse |=> n_cur_q >= 9'(INT_MIN - 8'h03) &&
		prescaler_hi == (n_cur_q > 9'h050)) else $error("feedback divide out of range");
endmodule

// ==== core/fnd_pkg.sv ====
// Constants, register map and carrier types of the fractional-N divider core.
// Assumes a single 250 MHz clock domain and a plain strobed register port.
package fnd_pkg;
	// ==========================================
	// Clock
	localparam int CLK_PERIOD_NS = 4;
	// ==========================================
	// Register map (word index on addr)
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_INT = 4'h1;
	localparam logic [3:0] OFS_FRACTION_WORD = 4'h2;
	localparam logic [3:0] OFS_MOD = 4'h3;
	localparam logic [3:0] OFS_TIMER = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;
	// Control field positions
	localparam int CTRL_DBL_BIT = 0;
	localparam int CTRL_TOG_BIT = 1;
	localparam int CTRL_PD_BIT = 2;
	localparam int CTRL_R_LSB = 4;
	// Status field positions
	localparam int STAT_CELLS_LSB = 0;
	localparam int STAT_STATE_LSB = 8;
	localparam int STAT_PRESC_BIT = 12;
	// ==========================================
	// Reset values
	localparam logic [3:0] RST_R_DIV = 4'h1;
	localparam logic [7:0] RST_INT = 8'h1A;
	localparam logic [11:0] RST_FRACTION_WORD = 12'h000;
	localparam logic [11:0] RST_MOD = 12'h002;
	localparam logic [9:0] RST_TIMER = 10'h010;
	// ==========================================
	// Divider and charge pump constants
	localparam logic [7:0] INT_MIN = 8'h1A;
	localparam logic [8:0] PRESC_HI_ABOVE = 9'h050;
	localparam logic [6:0] CELLS_ALL = 7'h40;
	localparam logic [6:0] CELLS_ONE = 7'h01;
	localparam logic [1:0] TICK_LAST = 2'h3;
	localparam int CELL_COUNT = 64;
	// ==========================================
	// Types
	typedef struct packed {
		logic [3:0] r_div;
		logic pd;
		logic tog;
		logic dbl;
	} fnd_cfg_t;
	typedef enum logic [1:0] {FL_NORMAL, FL_FAST, FL_STEP} fnd_fl_t;
endpackage

// ==== tb/fnd_osc_model.sv ====
// Reference oscillator and divided VCO seen by the divider core.
// Assumes rates are given in mclk cycles per half period, at least one.
`timescale 1ns/1ps
module fnd_osc_model (
	// Clock
	input wire logic mclk,
	// Rate control
	input wire logic [7:0] ref_half,
	input wire logic [7:0] vco_half,
	input wire logic vco_run,
	// Oscillator levels
	output logic ref_clock_in,
	output logic vco_div_in
);
	logic [7:0] rc_q = 8'h00;
	logic [7:0] vc_q = 8'h00;
	initial ref_clock_in = 1'b1;
	initial vco_div_in = 1'b0;
	// ==========================================
	// Free running reference
	always @(posedge mclk) begin
		rc_q <= (rc_q + 8'h01 >= ref_half) ? 8'h00 : rc_q + 8'h01;
		if (rc_q + 8'h01 >= ref_half) ref_clock_in <= !ref_clock_in;
	end
	// ==========================================
	// VCO output stands low while stopped
	always @(posedge mclk) begin
		vc_q <= (vc_q + 8'h01 >= vco_half) ? 8'h00 : vc_q + 8'h01;
		if (!vco_run) vco_div_in <= 1'b0;
		else if (vc_q + 8'h01 >= vco_half) vco_div_in <= !vco_div_in;
	end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the fractional-N divider core.
// Assumes fnd_pkg, fnd_core and fnd_osc_model compiled first.
`timescale 1ns/1ps
module tb_top;
	import fnd_pkg::*;
	// ==========================================
	// Signals
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic ref_clock_in, vco_div_in, ref_buf_connect, ref_input_shunt_switch;
	logic detector_ref_clk, pfd_up, pfd_down, prescaler_hi, fast_lock;
	logic [CELL_COUNT-1:0] cp_cell_en;
	logic [7:0] ref_half = 8'h05;
	logic [7:0] vco_half = 8'h01;
	logic vco_run = 1'b0;
	logic [31:0] d;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int falls, rises, hi, ups, downs, bad, r, tg, db, t;
	int vr, uf, vs, ia, fa, ma;
	// ==========================================
	// Clock and instances
	initial begin
		forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
	end
	fnd_core dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ref_clock_in(ref_clock_in), .vco_div_in(vco_div_in), .ref_buf_connect(ref_buf_connect),
		.ref_input_shunt_switch(ref_input_shunt_switch), .detector_ref_clk(detector_ref_clk),
		.pfd_up(pfd_up), .pfd_down(pfd_down), .prescaler_hi(prescaler_hi), .cp_cell_en(cp_cell_en),
		.fast_lock(fast_lock));
	fnd_osc_model osc_u (.mclk(mclk), .ref_half(ref_half), .vco_half(vco_half), .vco_run(vco_run),
		.ref_clock_in(ref_clock_in), .vco_div_in(vco_div_in));
	// ==========================================
	// Tasks
	task automatic check(string what, logic [64:0] seen, logic [64:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] near(int a, int b);
		return (a - b <= 2 && b - a <= 2) ? 32'h0000_0001 : 32'h0000_0000;
	endfunction
	// VCO edges over k frames against integer plus fraction over modulus
	function automatic int span_ok(int v, int k, int i, int f, int m);
		longint e;
		e = longint'(v) * m - longint'(k) * (longint'(i) * m + f);
		return int'(k >= 8 && e <= 6 * m && e >= -6 * m);
	endfunction
	task automatic wr_reg(logic [3:0] a, logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic watch(int n);
		logic pr;
		logic pq;
		{falls, rises, hi, ups, downs, bad} = '0;
		pr = ref_clock_in;
		pq = detector_ref_clk;
		repeat (n) begin
			@(posedge mclk);
			#1;
			falls += int'(pr && !ref_clock_in);
			rises += int'(!pq && detector_ref_clk);
			bad += int'(!pq && detector_ref_clk && ref_clock_in);
			hi += int'(detector_ref_clk);
			ups += int'(pfd_up);
			downs += int'(pfd_down);
			pr = ref_clock_in;
			pq = detector_ref_clk;
		end
	endtask
	// Each feedback pulse cancels a standing up pulse; count VCO rises between first and last
	task automatic span(int n);
		logic pu;
		logic pv;
		{vr, uf, vs} = '0;
		pu = pfd_up;
		pv = vco_div_in;
		repeat (n) begin
			@(posedge mclk);
			#1;
			vr += int'(!pv && vco_div_in);
			if (pu && !pfd_up) begin
				uf++;
				if (uf == 1) vr = 0;
				vs = vr;
			end
			pu = pfd_up;
			pv = vco_div_in;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 50000) begin
			errors++;
			give_verdict();
		end
	end
	// ==========================================
	// Tests
	initial begin
		void'($urandom(32'h2ff78dd4));
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check("buf", ref_buf_connect, 1);
		check("cells", cp_cell_en, 1);
		check("fl", fast_lock, 0);
		$display("test reset done");
		t = 1 + $urandom % 4095;
		wr_reg(OFS_MOD, t);
		rd_reg(OFS_MOD);
		check("mod", d, t);
		wr_reg(OFS_FRACTION_WORD, t - 1);
		rd_reg(OFS_FRACTION_WORD);
		check("fraction_word", d, t - 1);
		wr_reg(OFS_INT, 32'h0000_0005);
		check("fl_on", {fast_lock, cp_cell_en}, {1'b1, {CELL_COUNT{1'b1}}});
		rd_reg(OFS_INT);
		check("int", d, 32'h0000_0005);
		rd_reg(4'hF);
		check("unmapped", d, 0);
		$display("test registers done");
		wr_reg(OFS_TIMER, 32'h0000_0002);
		wr_reg(OFS_INT, 32'h0000_0028);
		for (t = 0; fast_lock !== 1'b0 && t < 2000; t++) begin
			@(posedge mclk);
			#1;
		end
		check("fl_time", int'(t >= 320 && t <= 410), 1);
		rd_reg(OFS_STATUS);
		check("status", d, 32'h0000_0001);
		$display("test fast lock done");
		for (int i = 0; i < 5; i++) begin
			r = (i == 0) ? 15 : (i == 1) ? 1 : 1 + $urandom % 15;
			tg = (i == 0) ? 1 : (i == 1) ? 0 : $urandom % 2;
			db = (i == 1) ? 1 : (i == 0) ? 0 : $urandom % 2;
			if (r % 2 == 0 && r > 2) tg = 1;
			wr_reg(OFS_CTRL, 32'((r << CTRL_R_LSB) | (tg << CTRL_TOG_BIT) | (db << CTRL_DBL_BIT)));
			rd_reg(OFS_CTRL);
			check("ctrl", d, 32'((r << CTRL_R_LSB) | (tg << CTRL_TOG_BIT) | (db << CTRL_DBL_BIT)));
			watch(2500);
			check("rate", near(rises, falls * (db + 1) / (r * (tg + 1))), 1);
			if (db == 0) check("edge", bad, 0);
			if (tg == 1) check("duty", near(hi * (db + 1) / (10 * r), rises), 1);
		end
		wr_reg(OFS_CTRL, 32'h0000_0010);
		$display("test reference path done");
		watch(400);
		check("lag", int'(ups > 0 && downs == 0), 1);
		ref_half <= 8'h64;
		vco_run <= 1'b1;
		watch(400);
		watch(4000);
		check("lead", int'(downs > ups), 1);
		ref_half <= 8'h05;
		$display("test detector done");
		wr_reg(OFS_MOD, 32'h0000_0000);
		wr_reg(OFS_INT, 32'h0000_0051);
		repeat (600) @(posedge mclk);
		rd_reg(OFS_STATUS);
		check("presc_hi", {prescaler_hi, d[STAT_PRESC_BIT]}, 2'b11);
		wr_reg(OFS_INT, 32'h0000_0050);
		repeat (600) @(posedge mclk);
		#1;
		check("presc_lo", prescaler_hi, 0);
		$display("test prescaler done");
		wr_reg(OFS_CTRL, 32'h0000_0014);
		check("pd_pins", {ref_buf_connect, ref_input_shunt_switch}, 2'b01);
		watch(200);
		check("pd_ref", rises, 0);
		wr_reg(OFS_CTRL, 32'h0000_0010);
		check("pd_off", {ref_buf_connect, ref_input_shunt_switch}, 2'b10);
		$display("test power down done");
		@(posedge mclk);
		rst <= 1'b1;
		ref_half <= 8'h02;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check("rst_again", {fast_lock, cp_cell_en}, {1'b0, 64'h0000_0000_0000_0001});
		rd_reg(OFS_MOD);
		check("rst_mod", d, RST_MOD);
		ma = 2 + $urandom % 4094;
		fa = $urandom % ma;
		ia = 26 + $urandom % 35;
		wr_reg(OFS_MOD, ma);
		wr_reg(OFS_FRACTION_WORD, fa);
		wr_reg(OFS_INT, ia);
		repeat (400) @(posedge mclk);
		span(6000);
		check("avg_div", span_ok(vs, uf - 1, ia, fa, ma), 1);
		wr_reg(OFS_INT, 32'h0000_0005);
		repeat (400) @(posedge mclk);
		span(6000);
		check("int_clamp", span_ok(vs, uf - 1, INT_MIN, fa, ma), 1);
		$display("test fractional divide done");
		give_verdict();
	end
endmodule
